// file: lvirs_regs.vh
// Notes on behaviour
// - level select writes ignored once armed in reset mode
// - control register locked while reset mode set
// - ram flag set on low voltage or instruction
// - ram flag set on watchdog, clock monitor, ram-access reset
// - ram flag cleared only by protected zero write
// - ram invalid flag never cleared by hardware
// - reset flags clear on zero, one keeps
// - reset setting beats simultaneous zero write
// - below-level flag drives voltage interrupt in interrupt mode
`ifndef LVIRS_REGS_VH
`define LVIRS_REGS_VH
// ----------------------------------------
// register offsets (8-bit address)
// ----------------------------------------
`define LVIRS_ADDR_W 8
`define LVIRS_OFF_MONCTL 8'h00
`define LVIRS_OFF_LVLSEL 8'h01
`define LVIRS_OFF_RAMSTAT 8'h02
`define LVIRS_OFF_RSTFLAG 8'h03
`define LVIRS_OFF_PROTECT 8'h04
`define LVIRS_OFF_IRQSTAT 8'h05
`define LVIRS_OFF_IRQMASK 8'h06
// ----------------------------------------
// monitor control fields
// ----------------------------------------
`define LVIRS_MON_ON_BIT 7
`define LVIRS_MON_MODE_BIT 1
`define LVIRS_MON_FLAG_BIT 0
`define LVIRS_MON_MASK 8'h82
// ----------------------------------------
// reset flag fields
// ----------------------------------------
`define LVIRS_RF_WDT_BIT 0
`define LVIRS_RF_CLM_BIT 1
`define LVIRS_RF_LVI_BIT 2
`define LVIRS_RF_RAM_BIT 3
`define LVIRS_PROTECT_KEY 8'ha5
// ----------------------------------------
// interrupt status fields
// ----------------------------------------
`define LVIRS_IRQ_LOWV_BIT 0
`define LVIRS_IRQ_RAMINV_BIT 1
`define LVIRS_IRQ_RESET_BIT 2
`define LVIRS_RST_MONCTL 8'h00
`define LVIRS_RST_LVLSEL 8'h00
`endif

// file: lvirs_sync.v
`timescale 1ns/1ps
`default_nettype none
module lvirs_sync
(
    // clock
    input wire mclk,
    input wire reset,
    input wire clkEn,
    // data
    input wire asyncIn,
    output reg syncOut
);
reg stage1_r;
always @(posedge mclk)
begin
    if (reset)
    begin
        stage1_r <= 1'b0;
        syncOut <= 1'b0;
    end
    else if (clkEn)
    begin
        stage1_r <= asyncIn;
        syncOut <= stage1_r;
    end
end
endmodule // lvirs_sync
`default_nettype wire

// file: lvirs_sticky.v
`timescale 1ns/1ps
`default_nettype none
module lvirs_sticky
(
    // clock
    input wire mclk,
    input wire reset,
    input wire clkEn,
    // control
    input wire setEvt,
    input wire clrReq,
    output reg flag_r
);
always @(posedge mclk)
begin
    if (reset)
        flag_r <= 1'b0;
    else if (clkEn)
    begin
        if (setEvt)
            flag_r <= 1'b1;
        else if (clrReq)
            flag_r <= 1'b0;
    end
end
endmodule // lvirs_sticky
`default_nettype wire

// file: lvirs_top.v
`timescale 1ns/1ps
`default_nettype none
`include "lvirs_regs.vh"
module lvirs_top
(
    // clock and reset
    input wire mclk,
    input wire reset,
    input wire clkEn,
    // register port
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdata,
    // reset sources (pins / analog)
    input wire belowLevelIn,
    input wire wdtResetIn,
    input wire clkMonResetIn,
    input wire ramAccessResetIn,
    input wire lowVoltResetIn,
    // outputs
    output reg voltageInterrupt,
    output reg ramInvalidFlag,
    output reg detectorOn,
    output reg voltageLevelSel,
    output reg irq
);
// ----------------------------------------
// input synchronisers
// ----------------------------------------
wire belowSync;
wire wdtSync;
wire clmSync;
wire ramSync;
wire lviSync;
lvirs_sync uSyncBelow (.mclk(mclk), .reset(reset), .clkEn(clkEn), .asyncIn(belowLevelIn), .syncOut(belowSync));
lvirs_sync uSyncWdt (.mclk(mclk), .reset(reset), .clkEn(clkEn), .asyncIn(wdtResetIn), .syncOut(wdtSync));
lvirs_sync uSyncClm (.mclk(mclk), .reset(reset), .clkEn(clkEn), .asyncIn(clkMonResetIn), .syncOut(clmSync));
lvirs_sync uSyncRam (.mclk(mclk), .reset(reset), .clkEn(clkEn), .asyncIn(ramAccessResetIn), .syncOut(ramSync));
lvirs_sync uSyncLvi (.mclk(mclk), .reset(reset), .clkEn(clkEn), .asyncIn(lowVoltResetIn), .syncOut(lviSync));

// ----------------------------------------
// decode
// ----------------------------------------
function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
        hit = (addr == off);
    end
endfunction

wire wrMon = regWr && hit(regAddr, `LVIRS_OFF_MONCTL);
wire wrLvl = regWr && hit(regAddr, `LVIRS_OFF_LVLSEL);
wire wrRam = regWr && hit(regAddr, `LVIRS_OFF_RAMSTAT);
wire wrRf = regWr && hit(regAddr, `LVIRS_OFF_RSTFLAG);
wire wrKey = regWr && hit(regAddr, `LVIRS_OFF_PROTECT);
wire wrIst = regWr && hit(regAddr, `LVIRS_OFF_IRQSTAT);
wire wrMsk = regWr && hit(regAddr, `LVIRS_OFF_IRQMASK);

// ----------------------------------------
// register lock
// ----------------------------------------
reg [7:0] monCtl_r;
reg lvlSel_r;
reg lock_r;
reg unlockKey_r;
reg [7:0] irqMask_r;
wire modeSet = monCtl_r[`LVIRS_MON_MODE_BIT];
wire otherReset = wdtSync | clmSync | ramSync;
wire armed = monCtl_r[`LVIRS_MON_ON_BIT] & modeSet;
wire lock_nxt = otherReset ? 1'b0 : (lock_r | armed);

always @(posedge mclk)
begin
    if (reset)
    begin
        lock_r <= 1'b0;
        monCtl_r <= `LVIRS_RST_MONCTL;
        lvlSel_r <= 1'b0;
    end
    else if (clkEn)
    begin
        lock_r <= lock_nxt;
        // another reset source restores the monitor registers
        if (otherReset)
        begin
            monCtl_r <= `LVIRS_RST_MONCTL;
            lvlSel_r <= 1'b0;
        end
        else
        begin
            if (wrMon && !lock_r && !modeSet)
                monCtl_r <= regWdata & `LVIRS_MON_MASK;
            if (wrLvl && !lock_r && !armed)
                lvlSel_r <= regWdata[0];
        end
    end
end

// ----------------------------------------
// protected write sequence
// ----------------------------------------
always @(posedge mclk)
begin
    if (reset)
        unlockKey_r <= 1'b0;
    else if (clkEn && regWr)
        unlockKey_r <= wrKey && (regWdata == `LVIRS_PROTECT_KEY);
end

// ----------------------------------------
// ram data status flag
// ----------------------------------------
wire ramSet = (belowSync & monCtl_r[`LVIRS_MON_ON_BIT])
    | (wrRam & regWdata[0])
    | wdtSync | clmSync | ramSync;
wire ramClr = wrRam & unlockKey_r & ~regWdata[0];
wire ramFlag;
lvirs_sticky uRamFlag
(
    .mclk(mclk),
    .reset(reset),
    .clkEn(clkEn),
    .setEvt(ramSet),
    .clrReq(ramClr),
    .flag_r(ramFlag)
);

// ----------------------------------------
// reset flags: zero clears, one keeps
// ----------------------------------------
reg [3:0] rstFlag_r;
wire [3:0] rfSet = {ramSync, lviSync, clmSync, wdtSync};
wire [3:0] rfClr = wrRf ? ~regWdata[3:0] : 4'h0;
always @(posedge mclk)
begin
    if (reset)
        rstFlag_r <= 4'h0;
    else if (clkEn)
        rstFlag_r <= rfSet | (rstFlag_r & ~rfClr);
end

// ----------------------------------------
// interrupt status and mask
// ----------------------------------------
reg [2:0] irqStat_r;
reg belowPrev_r;
wire lowvInt = monCtl_r[`LVIRS_MON_ON_BIT] & ~modeSet & belowSync;
wire [2:0] irqEvt = {(|rfSet), ramSet & ~ramFlag, lowvInt & ~belowPrev_r};
wire [2:0] irqClr = wrIst ? regWdata[2:0] : 3'h0;
always @(posedge mclk)
begin
    if (reset)
    begin
        irqStat_r <= 3'h0;
        irqMask_r <= 8'h00;
        belowPrev_r <= 1'b0;
    end
    else if (clkEn)
    begin
        belowPrev_r <= lowvInt;
        irqStat_r <= irqEvt | (irqStat_r & ~irqClr);
        if (wrMsk)
            irqMask_r <= {5'h00, regWdata[2:0]};
    end
end

// ----------------------------------------
// outputs and read data
// ----------------------------------------
always @(posedge mclk)
begin
    if (reset)
    begin
        regRdata <= 8'h00;
        voltageInterrupt <= 1'b0;
        ramInvalidFlag <= 1'b0;
        detectorOn <= 1'b0;
        voltageLevelSel <= 1'b0;
        irq <= 1'b0;
    end
    else if (clkEn)
    begin
        voltageInterrupt <= lowvInt;
        ramInvalidFlag <= ramFlag;
        detectorOn <= monCtl_r[`LVIRS_MON_ON_BIT];
        voltageLevelSel <= lvlSel_r;
        irq <= |(irqStat_r & irqMask_r[2:0]);
        regRdata <= 8'h00;
        if (regRd)
        begin
            case (regAddr)
                `LVIRS_OFF_MONCTL: regRdata <= monCtl_r | {7'h00, belowSync};
                `LVIRS_OFF_LVLSEL: regRdata <= {7'h00, lvlSel_r};
                `LVIRS_OFF_RAMSTAT: regRdata <= {7'h00, ramFlag};
                `LVIRS_OFF_RSTFLAG: regRdata <= {4'h0, rstFlag_r};
                `LVIRS_OFF_PROTECT: regRdata <= {lock_r, 6'h00, unlockKey_r};
                `LVIRS_OFF_IRQSTAT: regRdata <= {5'h00, irqStat_r};
                `LVIRS_OFF_IRQMASK: regRdata <= irqMask_r;
                default: regRdata <= 8'h00;
            endcase
        end
    end
end
endmodule // lvirs_top
`default_nettype wire

// file: lvirs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lvirs_checker
(
    // clock and reset
    input wire mclk,
    input wire reset,
    // register port
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    input wire [7:0] regRdata,
    // sources and state
    input wire belowLevelIn,
    input wire wdtResetIn,
    input wire clkMonResetIn,
    input wire ramAccessResetIn,
    input wire voltageInterrupt,
    input wire ramInvalidFlag,
    input wire detectorOn,
    input wire voltageLevelSel
);
    // ---
    // recent non-detector resets
    // ---
    wire anyRst = wdtResetIn | clkMonResetIn | ramAccessResetIn;
    reg [4:0] rstHist_r;
    always @(posedge mclk)
    begin
        rstHist_r <= reset ? 5'h00 : {rstHist_r[3:0], anyRst};
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence rdUnmapped; regRd && regAddr == 8'h07; endsequence
    wire ramZeroWr = regWr && regAddr == 8'h02 && !regWdata[0];
    wire lvlOneWr = regWr && regAddr == 8'h01 && regWdata[0];
    wire monWr = regWr && regAddr == 8'h00;
    rd_idle_zero_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data outside answer cycle");
    unmapped_read_a: assert property (rdUnmapped |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    vint_needs_on_a: assert property (voltageInterrupt |-> detectorOn)
        else $error("voltage interrupt with detector off");
    ram_clear_wr_a: assert property ($fell(ramInvalidFlag) |-> $past(ramZeroWr, 2))
        else $error("ram flag cleared without zero write");
    ram_set_rst_a: assert property ($rose(anyRst) |-> ##[1:6] ramInvalidFlag)
        else $error("ram flag not set by reset source");
    ram_set_low_a: assert property ($rose(belowLevelIn) && detectorOn |-> ##[1:6] ramInvalidFlag)
        else $error("ram flag not set by low supply");
    lvl_rise_wr_a: assert property ($rose(voltageLevelSel) |-> $past(lvlOneWr, 2))
        else $error("level select rose without write");
    mon_fall_src_a: assert property ($fell(detectorOn) |-> $past(monWr, 2) || (|rstHist_r))
        else $error("detector dropped without write or reset");
endmodule // lvirs_checker
bind lvirs_top lvirs_checker i_lvirs_checker (.mclk, .reset, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .belowLevelIn, .wdtResetIn, .clkMonResetIn, .ramAccessResetIn, .voltageInterrupt, .ramInvalidFlag,
    .detectorOn, .voltageLevelSel);
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb;
    logic mclk = 0, reset = 1, regWr = 0, regRd = 0, below = 0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00;
    logic [3:0] src = 4'h0;
    wire [7:0] regRdata;
    wire vInt, ramF, detOn, lvlSel, irq;
    int err_count = 0, checked = 0;
    always #2 mclk = ~mclk;
    lvirs_top i_lvirs_top (.mclk(mclk), .reset(reset), .clkEn(1'b1), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .belowLevelIn(below), .wdtResetIn(src[0]),
        .clkMonResetIn(src[1]), .ramAccessResetIn(src[2]), .lowVoltResetIn(src[3]), .voltageInterrupt(vInt),
        .ramInvalidFlag(ramF), .detectorOn(detOn), .voltageLevelSel(lvlSel), .irq(irq));
    // ---
    // access tasks
    // ---
    task wait_n(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task rc(input [7:0] a, input [7:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        `CHK("regRdata", e, regRdata)
    endtask
    task pulse(input [3:0] m);
        @(posedge mclk);
        src <= m;
        wait_n(4);
        src <= 4'h0;
        wait_n(5);
    endtask
    task ramClr;
        wr(8'h04, 8'ha5);
        wr(8'h02, 8'h00);
    endtask
    task summarize;
        if (err_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #20000;
        err_count++;
        summarize();
    end
    initial
    begin
        wait_n(3);
        reset <= 1'b0;
        rc(8'h07, 8'h00);
        wr(8'h02, 8'h01);
        rc(8'h02, 8'h01);
        wr(8'h02, 8'h00);
        rc(8'h02, 8'h01);
        ramClr();
        rc(8'h02, 8'h00);
        wr(8'h01, 8'h01);
        wr(8'h00, 8'h82);
        wr(8'h01, 8'h00);
        wr(8'h00, 8'h00);
        wait_n(1);
        `CHK("voltageLevelSel", 1'b1, lvlSel)
        pulse(4'h8);
        wr(8'h00, 8'h00);
        rc(8'h00, 8'h82);
        for (int i = 0; i < 3; i++)
        begin
            ramClr();
            wr(8'h03, 8'h00);
            pulse(4'h1 << i);
            `CHK("ramInvalidFlag", 1'b1, ramF)
            wr(8'h03, 8'hff);
            rc(8'h03, i == 2 ? 8'h08 : 8'h01 << i);
            rc(8'h00, 8'h00);
        end
        wr(8'h03, 8'h00);
        rc(8'h03, 8'h00);
        ramClr();
        wr(8'h05, 8'h07);
        wr(8'h00, 8'h80);
        below <= 1'b1;
        wait_n(6);
        `CHK("detectorOn", 1'b1, detOn)
        `CHK("voltageInterrupt", 1'b1, vInt)
        `CHK("ramInvalidFlag", 1'b1, ramF)
        rc(8'h00, 8'h81);
        `CHK("irq", 1'b0, irq)
        wr(8'h06, 8'h01);
        wait_n(2);
        `CHK("irq", 1'b1, irq)
        wr(8'h05, 8'h01);
        wait_n(2);
        `CHK("irq", 1'b0, irq)
        below <= 1'b0;
        wait_n(5);
        `CHK("voltageInterrupt", 1'b0, vInt)
        summarize();
    end
endmodule // tb
`default_nettype wire
